// [hdl/pmc_pkg.sv]
// Contract
// - Medium-speed sleep with direct flag goes high-speed
// - Sleep states old period, exception states new
// - Subactive sleep with watch select goes high-speed
// - Subactive exit adds settling wait at new period
// - Subactive sleep with medium flag goes medium-speed
// - Subactive transfers pass through watch mode
// - Standby peripheral clock stops, halts as standby
// - Writing 0 puts peripheral into standby
// - Writing 1 releases peripheral, restores clock
// - Both clock-stop registers reset to all ones
// - First register gates timers, converter, serials
// - Second register gates lcd, pwm, watchdog, counter
// - Gated peripheral keeps pending interrupt request
// - After transfer take exception, else sleep/watch
package pmc_pkg;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] off_control = 8'h00; // Mode control bits
  localparam logic [7:0] off_stop_one = 8'h04; // clock_stop_one
  localparam logic [7:0] off_stop_two = 8'h08; // clock_stop_two
  localparam logic [7:0] off_status = 8'h0C; // Mode and busy status
  localparam logic [7:0] off_sleep = 8'h10; // Sleep instruction strobe
  // ----------------------------------------------------------------
  // Control field positions
  // ----------------------------------------------------------------
  localparam int bit_standby_select = 0;
  localparam int bit_low_speed_on = 1;
  localparam int bit_medium_speed_on = 2;
  localparam int bit_direct_transfer_on = 3;
  localparam int bit_timer_watch_select = 4;
  localparam int bit_wait_lo = 5; // wait_time_select, 3 bits
  localparam int bit_mdiv_lo = 8; // Medium-speed divider select, 2 bits
  localparam int bit_sdiv_lo = 10; // Subclock divider select, 2 bits
  localparam int bit_dt_irq_en = 12; // Direct-transfer interrupt enable
  localparam logic [12:0] control_reset = 13'h0000;
  localparam logic [7:0] stop_reset = 8'hFF;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int sleep_states = 2; // Sleep instruction states
  localparam int internal_states = 1; // Internal processing states
  localparam int exception_states = 14; // Exception handling states
  localparam int pre_states = sleep_states + internal_states;
  localparam logic [1:0] okay = 2'b00;
  localparam logic [1:0] slverr = 2'b10;
  // Operating modes
  typedef enum logic [2:0] {
    mode_high = 3'b000,
    mode_medium = 3'b001,
    mode_sub = 3'b010,
    mode_sleep = 3'b011,
    mode_watch = 3'b100
  } op_mode_t;
endpackage

// [hdl/pmc_tick_if.sv]
`timescale 1ns/1ps
// Carries the state-rate enable from the divider to the sequencer
interface pmc_tick_if;
  logic [2:0] sel; // Divider select
  logic tick; // One-cycle state enable
  modport gen (input sel, output tick);
  modport use_ (output sel, input tick);
endinterface

// [hdl/pmc_divider.sv]
`timescale 1ns/1ps
// Makes one state-enable pulse every 2^sel cycles of clk_sys
module pmc_divider (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Synchronous reset, low
  pmc_tick_if.gen tk // Select in, tick out
);
  logic [7:0] cnt_q; // Free-running prescaler
  logic [7:0] cnt_d;
  logic tick_q;
  logic tick_d;
  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    cnt_d = cnt_q + 8'h01;
    tick_d = ((cnt_q & ((8'h01 << tk.sel) - 8'h01)) == 8'h00);
  end
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_q <= 8'h00;
      tick_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      tick_q <= tick_d;
    end
  end
  assign tk.tick = tick_q;
endmodule

// [hdl/power_mode_ctrl.sv]
// Decided for this implementation: the register offsets and register access over AXI4-Lite.
`timescale 1ns/1ps
// Operating-mode sequencer and module clock gating
module power_mode_ctrl (
  input wire logic clk_sys, // 200 MHz system clock
  input wire logic rstn, // Synchronous reset, low
  input wire logic [31:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [11:0] periph_irq, // Peripheral interrupt requests
  output logic [11:0] periph_clk_en, // Per-peripheral clock enable
  output logic [11:0] periph_irq_hold, // Requests seen by the CPU
  output logic [2:0] op_mode, // Current operating mode
  output logic dt_exception, // Direct-transfer exception pulse
  output logic cpu_run // CPU may execute
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    seq_idle = 2'b00,
    seq_pre = 2'b01, // Sleep and internal states, old period
    seq_wait = 2'b10, // Settling states, new period
    seq_exc = 2'b11 // Exception states, new period
  } seq_t;
  seq_t seq_q, seq_d;
  pmc_pkg::op_mode_t mode_q, mode_d; // Current mode
  pmc_pkg::op_mode_t target_q, target_d; // Mode after transfer
  pmc_pkg::op_mode_t from_q, from_d; // Mode before transfer, sets the old rate
  logic [15:0] cnt_q, cnt_d; // State counter
  logic [12:0] ctrl_q, ctrl_d; // Control register
  logic [7:0] stop1_q, stop1_d; // clock_stop_one
  logic [7:0] stop2_q, stop2_d; // clock_stop_two
  logic [11:0] irq_q, irq_d; // Latched requests
  logic dtx_q, dtx_d;
  logic [11:0] clken_q, clken_d;
  logic cpu_run_q, cpu_run_d; // CPU may execute, registered
  // Bus channel state
  logic [31:0] awaddr_q, awaddr_d;
  logic aw_have_q, aw_have_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic w_have_q, w_have_d;
  logic bvalid_q, bvalid_d;
  logic [1:0] bresp_q, bresp_d;
  logic rvalid_q, rvalid_d;
  logic [31:0] rdata_q, rdata_d;
  logic [1:0] rresp_q, rresp_d;
  logic sleep_req; // Sleep instruction written this cycle
  logic [15:0] wait_states; // Settling states chosen
  logic [11:0] gates;
  pmc_tick_if tk ();
  pmc_divider u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tk(tk)
  );
  // ----------------------------------------------------------------
  // Divider select: old period in pre phase, new one afterwards
  // ----------------------------------------------------------------
  always_comb begin
    pmc_pkg::op_mode_t m;
    m = (seq_q == seq_pre) ? from_q : (seq_q == seq_idle) ? mode_q : target_q;
    case (m)
      pmc_pkg::mode_medium: tk.sel = {1'b0, ctrl_q[pmc_pkg::bit_mdiv_lo +: 2]} + 3'd1;
      pmc_pkg::mode_sub: tk.sel = {1'b0, ctrl_q[pmc_pkg::bit_sdiv_lo +: 2]} + 3'd4;
      default: tk.sel = 3'd0;
    endcase
  end
  // Settling wait table from wait_time_select
  always_comb begin
    case (ctrl_q[pmc_pkg::bit_wait_lo +: 3])
      3'd0: wait_states = 16'h2000;
      3'd1: wait_states = 16'h4000;
      3'd2: wait_states = 16'h0400;
      3'd3: wait_states = 16'h0800;
      3'd4: wait_states = 16'h0010;
      default: wait_states = 16'h0100;
    endcase
  end
  // ----------------------------------------------------------------
  // Bus write and read decode
  // ----------------------------------------------------------------
  always_comb begin
    logic wr_go;
    logic [7:0] wa;
    logic [7:0] ra;
    wr_go = aw_have_q && w_have_q && !bvalid_q;
    wa = awaddr_q[7:0];
    ra = s_axi_araddr[7:0];
    awaddr_d = awaddr_q;
    aw_have_d = aw_have_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    w_have_d = w_have_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rdata_d = rdata_q;
    rresp_d = rresp_q;
    ctrl_d = ctrl_q;
    stop1_d = stop1_q;
    stop2_d = stop2_q;
    sleep_req = 1'b0;
    if (s_axi_awvalid && !aw_have_q) begin
      awaddr_d = s_axi_awaddr;
      aw_have_d = 1'b1;
    end
    if (s_axi_wvalid && !w_have_q) begin
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
      w_have_d = 1'b1;
    end
    if (wr_go) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = pmc_pkg::okay;
      case (wa)
        pmc_pkg::off_control: begin
          if (wstrb_q[0]) ctrl_d[7:0] = wdata_q[7:0];
          if (wstrb_q[1]) ctrl_d[12:8] = wdata_q[12:8];
        end
        pmc_pkg::off_stop_one: if (wstrb_q[0]) stop1_d = wdata_q[7:0];
        pmc_pkg::off_stop_two: if (wstrb_q[0]) stop2_d = {4'h0, wdata_q[3:0]} | 8'hF0;
        pmc_pkg::off_status: ;
        pmc_pkg::off_sleep: sleep_req = wstrb_q[0] && wdata_q[0] && seq_q == seq_idle;
        default: bresp_d = pmc_pkg::slverr;
      endcase
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = pmc_pkg::okay;
      case (ra)
        pmc_pkg::off_control: rdata_d = {19'h0, ctrl_q};
        pmc_pkg::off_stop_one: rdata_d = {24'h0, stop1_q};
        pmc_pkg::off_stop_two: rdata_d = {24'h0, stop2_q};
        pmc_pkg::off_status: rdata_d = {26'h0, seq_q, 1'b0, mode_q};
        pmc_pkg::off_sleep: rdata_d = 32'h0000_0000;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = pmc_pkg::slverr;
        end
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
  end
  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    logic ss, ls, ms, dt, tw, ie;
    ss = ctrl_q[pmc_pkg::bit_standby_select];
    ls = ctrl_q[pmc_pkg::bit_low_speed_on];
    ms = ctrl_q[pmc_pkg::bit_medium_speed_on];
    dt = ctrl_q[pmc_pkg::bit_direct_transfer_on];
    tw = ctrl_q[pmc_pkg::bit_timer_watch_select];
    ie = ctrl_q[pmc_pkg::bit_dt_irq_en];
    seq_d = seq_q;
    mode_d = mode_q;
    target_d = target_q;
    from_d = from_q;
    cnt_d = cnt_q;
    dtx_d = 1'b0;
    case (seq_q)
      seq_idle: begin
        if (sleep_req && dt) begin
          target_d = mode_q;
          if ((mode_q == pmc_pkg::mode_medium || mode_q == pmc_pkg::mode_high)
              && !ss && !ls) begin
            target_d = ms ? pmc_pkg::mode_medium : pmc_pkg::mode_high;
          end else if (mode_q == pmc_pkg::mode_sub && ss && !ls && tw) begin
            target_d = ms ? pmc_pkg::mode_medium : pmc_pkg::mode_high;
          end else if (mode_q != pmc_pkg::mode_sub && ss && ls && tw) begin
            target_d = pmc_pkg::mode_sub;
          end
          if (target_d != mode_q || mode_q == pmc_pkg::mode_sub) begin
            seq_d = seq_pre;
            from_d = mode_q;
            // The request lands mid-state, so one extra edge keeps three whole states
            cnt_d = 16'(pmc_pkg::pre_states + 1);
            // Subactive transfers run through watch mode
            mode_d = (mode_q == pmc_pkg::mode_sub || target_d == pmc_pkg::mode_sub) ?
                     pmc_pkg::mode_watch : pmc_pkg::mode_sleep;
            target_d = (target_d == mode_q) ? pmc_pkg::mode_high : target_d;
          end
        end
      end
      seq_pre: begin
        if (tk.tick) begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            if (!ie) begin
              seq_d = seq_idle;
            end else if (mode_q == pmc_pkg::mode_watch && target_q != pmc_pkg::mode_sub) begin
              seq_d = seq_wait;
              cnt_d = wait_states;
            end else begin
              seq_d = seq_exc;
              mode_d = target_q;
              cnt_d = 16'(pmc_pkg::exception_states);
              dtx_d = 1'b1;
            end
          end
        end
      end
      seq_wait: begin
        if (tk.tick) begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            seq_d = seq_exc;
            mode_d = target_q;
            cnt_d = 16'(pmc_pkg::exception_states);
            dtx_d = 1'b1;
          end
        end
      end
      seq_exc: begin
        if (tk.tick) begin
          cnt_d = cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) seq_d = seq_idle;
        end
      end
      default: seq_d = seq_idle;
    endcase
    // Held in the sleep and settling phases, and while parked asleep
    cpu_run_d = (seq_d == seq_exc) || (seq_d == seq_idle
                && mode_d != pmc_pkg::mode_sleep && mode_d != pmc_pkg::mode_watch);
  end
  // ----------------------------------------------------------------
  // Clock gating and held requests
  // ----------------------------------------------------------------
  assign gates = {stop2_q[3:0], stop1_q};
  always_comb begin
    clken_d = gates;
    // A gated peripheral freezes its request as it was
    irq_d = (periph_irq & gates) | (irq_q & ~gates);
  end
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      seq_q <= seq_idle;
      mode_q <= pmc_pkg::mode_medium;
      target_q <= pmc_pkg::mode_medium;
      cnt_q <= 16'h0000;
      ctrl_q <= pmc_pkg::control_reset;
      stop1_q <= pmc_pkg::stop_reset;
      stop2_q <= pmc_pkg::stop_reset;
      irq_q <= 12'h000;
      dtx_q <= 1'b0;
      cpu_run_q <= 1'b1;
      from_q <= pmc_pkg::mode_medium;
      clken_q <= 12'hFFF;
      awaddr_q <= 32'h0000_0000;
      aw_have_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= 2'b00;
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= 2'b00;
    end else begin
      seq_q <= seq_d;
      mode_q <= mode_d;
      target_q <= target_d;
      cnt_q <= cnt_d;
      ctrl_q <= ctrl_d;
      stop1_q <= stop1_d;
      stop2_q <= stop2_d;
      irq_q <= irq_d;
      dtx_q <= dtx_d;
      cpu_run_q <= cpu_run_d;
      from_q <= from_d;
      clken_q <= clken_d;
      awaddr_q <= awaddr_d;
      aw_have_q <= aw_have_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      bresp_q <= bresp_d;
      rvalid_q <= rvalid_d;
      rdata_q <= rdata_d;
      rresp_q <= rresp_d;
    end
  end
  assign s_axi_awready = !aw_have_q;
  assign s_axi_wready = !w_have_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = !rvalid_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;
  assign periph_clk_en = clken_q;
  assign periph_irq_hold = irq_q;
  assign op_mode = mode_q;
  assign dt_exception = dtx_q;
  assign cpu_run = cpu_run_q;
endmodule

// [verification/power_mode_props.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Port-level checker for the mode sequencer and clock gating
// ------------------------------------------------------------
module power_mode_props (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Synchronous reset, low
  input wire logic [1:0] s_axi_bresp, // Write response
  input wire logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic [11:0] periph_irq, // Live requests
  input wire logic [11:0] periph_clk_en, // Clock enables
  input wire logic [11:0] periph_irq_hold, // Requests seen by the CPU
  input wire logic [2:0] op_mode, // Operating mode
  input wire logic dt_exception, // Exception start pulse
  input wire logic cpu_run // CPU may execute
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Every peripheral clock runs straight out of reset
  a_reset_clk_on: assert property ($rose(rstn) |-> periph_clk_en == 12'hFFF)
    else $error("clock enables not all ones after reset");
  // A response is held until the master takes it
  a_bresp_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  // A gated peripheral is frozen, its pending request included
  a_gated_frozen: assert property ($stable(periph_clk_en) |->
    ((periph_irq_hold ^ $past(periph_irq_hold)) & ~periph_clk_en) == 12'h000)
    else $error("gated request changed");
  // A running peripheral passes its request through one cycle later
  a_live_follows: assert property (((periph_irq_hold ^ $past(periph_irq))
    & periph_clk_en & $past(periph_clk_en)) == 12'h000)
    else $error("running request not passed on");
  // Subactive is only ever left or entered through watch mode
  a_sub_via_watch: assert property ($past(op_mode) == pmc_pkg::mode_sub
    && op_mode != pmc_pkg::mode_sub |-> op_mode == pmc_pkg::mode_watch)
    else $error("left subactive without watch");
  a_sub_entry: assert property ($past(op_mode) != pmc_pkg::mode_sub
    && op_mode == pmc_pkg::mode_sub |-> $past(op_mode) == pmc_pkg::mode_watch)
    else $error("entered subactive without watch");
  // Exception handling is a single pulse, taken in a mode that runs code
  a_exc_pulse: assert property (dt_exception |=> !dt_exception)
    else $error("exception pulse too long");
  a_exc_active: assert property (dt_exception |->
    op_mode inside {pmc_pkg::mode_high, pmc_pkg::mode_medium, pmc_pkg::mode_sub})
    else $error("exception outside a running mode");
  a_stop_no_run: assert property (
    op_mode inside {pmc_pkg::mode_sleep, pmc_pkg::mode_watch} |-> !cpu_run)
    else $error("cpu runs in sleep or watch");
  c_to_high: cover property (dt_exception && op_mode == pmc_pkg::mode_high);
  c_watch: cover property (op_mode == pmc_pkg::mode_watch);
  c_gated: cover property (periph_clk_en != 12'hFFF && periph_irq_hold != 12'h000);
endmodule
bind power_mode_ctrl power_mode_props i_props (.clk_sys(clk_sys), .rstn(rstn),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .periph_irq(periph_irq), .periph_clk_en(periph_clk_en), .periph_irq_hold(periph_irq_hold),
  .op_mode(op_mode), .dt_exception(dt_exception), .cpu_run(cpu_run));

// [verification/periph_model.sv]
`timescale 1ns/1ps
// ------------------------------------------------------------
// Peripheral side: pending requests that only move with a clock
// ------------------------------------------------------------
module periph_model (
  input wire logic clk_sys, // System clock
  input wire logic rstn, // Synchronous reset, low
  input wire logic [11:0] clk_en, // Clock enable per peripheral
  input wire logic [11:0] fire, // Raise a request
  input wire logic [11:0] serviced, // Clear a request
  output logic [11:0] irq // Pending requests
);
  // A stopped peripheral can neither raise nor clear, so a request stays pending
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      irq <= 12'h000;
    end else begin
      irq <= (irq & ~(serviced & clk_en)) | (fire & clk_en);
    end
  end
endmodule

// [verification/power_mode_and_module_clock_gating_test.sv]
`timescale 1ns/1ps
module power_mode_and_module_clock_gating_test;
  // ------------------------------------------------------------
  // Signals
  // ------------------------------------------------------------
  logic clk_sys = 1'b0; // 200 MHz clock
  logic rstn = 1'b0; // Reset, low
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [3:0] s_axi_wstrb = 4'hF; // Whole word always
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, rd;
  logic [11:0] periph_irq, periph_clk_en, periph_irq_hold;
  logic [11:0] fire = 12'h000, serviced = 12'h000;
  logic [2:0] op_mode;
  logic dt_exception, cpu_run, seen;
  logic [1:0] rsp;
  int error_cnt = 0, samples_checked = 0, cyc = 0, n;
  logic [12:0] ctl [6];
  logic [2:0] tgt [6];
  int lo [6], per [6];
  power_mode_ctrl i_dut (.clk_sys(clk_sys), .rstn(rstn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .periph_irq(periph_irq), .periph_clk_en(periph_clk_en),
    .periph_irq_hold(periph_irq_hold), .op_mode(op_mode), .dt_exception(dt_exception),
    .cpu_run(cpu_run));
  periph_model i_periph (.clk_sys(clk_sys), .rstn(rstn), .clk_en(periph_clk_en), .fire(fire),
    .serviced(serviced), .irq(periph_irq));
  // ------------------------------------------------------------
  // Clock and hang guard
  // ------------------------------------------------------------
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Whole run is under two thousand cycles; the ceiling leaves ample margin
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // Address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk_sys);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clk_sys);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  // Reset for 20 cycles, then check clock enables, mode and the three register reset values
  task automatic reset_and_check();
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (20) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk("clk_en", 32'h0FFF, 32'(periph_clk_en));
    chk("op_mode", 32'(pmc_pkg::mode_medium), 32'(op_mode));
    axi_rd(pmc_pkg::off_stop_one, rd, rsp);
    chk("clock_stop_one", 32'h00FF, rd);
    axi_rd(pmc_pkg::off_stop_two, rd, rsp);
    chk("clock_stop_two", 32'h00FF, rd);
    axi_rd(pmc_pkg::off_control, rd, rsp);
    chk("control", 32'h0000, rd);
    $display("test reset done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    // Control word, target mode, base time in cycles (0 = untimed), old state period
    ctl = '{13'h1008, 13'h100C, 13'h101B, 13'h1099, 13'h101B, 13'h109D};
    tgt = '{pmc_pkg::mode_high, pmc_pkg::mode_medium, pmc_pkg::mode_sub,
      pmc_pkg::mode_high, pmc_pkg::mode_sub, pmc_pkg::mode_medium};
    lo = '{6, 3, 0, 64, 0, 80};
    per = '{2, 1, 0, 16, 0, 16};
    reset_and_check();
    // Gate each peripheral alone, then release it
    for (int i = 0; i < 12; i++) begin
      axi_wr(i < 8 ? pmc_pkg::off_stop_one : pmc_pkg::off_stop_two,
        32'(8'hFF & ~(8'h01 << (i % 8))), rsp);
      repeat (2) @(posedge clk_sys);
      chk("clk_en gated", 32'h0FFF & 32'(~(12'h001 << i)), 32'(periph_clk_en));
      axi_wr(i < 8 ? pmc_pkg::off_stop_one : pmc_pkg::off_stop_two, 32'h00FF, rsp);
      repeat (2) @(posedge clk_sys);
      chk("clk_en released", 32'h0FFF, 32'(periph_clk_en));
    end
    $display("test gating done");
    // A request raised, then its peripheral gated before service
    fire <= 12'h001;
    @(posedge clk_sys);
    fire <= 12'h000;
    repeat (3) @(posedge clk_sys);
    chk("irq_hold raised", 32'h0001, 32'(periph_irq_hold));
    axi_wr(pmc_pkg::off_stop_one, 32'h00FE, rsp);
    serviced <= 12'h001;
    repeat (4) @(posedge clk_sys);
    chk("irq_hold gated", 32'h0001, 32'(periph_irq_hold));
    axi_wr(pmc_pkg::off_stop_one, 32'h00FF, rsp);
    repeat (4) @(posedge clk_sys);
    serviced <= 12'h000;
    chk("irq_hold cleared", 32'h0000, 32'(periph_irq_hold));
    $display("test pending request done");
    axi_wr(8'h14, 32'h1, rsp);
    chk("unmapped bresp", 32'(pmc_pkg::slverr), 32'(rsp));
    axi_rd(8'h14, rd, rsp);
    chk("unmapped rresp", 32'(pmc_pkg::slverr), 32'(rsp));
    chk("unmapped rdata", 32'h0, rd);
    $display("test unmapped done");
    // Chain of direct transfers through all active modes
    for (int k = 0; k < 6; k++) begin
      axi_wr(pmc_pkg::off_control, 32'(ctl[k]), rsp);
      axi_wr(pmc_pkg::off_sleep, 32'h1, rsp);
      n = 0;
      while (dt_exception !== 1'b1 && n < 3000) begin
        @(posedge clk_sys);
        n++;
      end
      chk("dt_exception", 32'h1, 32'(dt_exception));
      chk("mode at exception", 32'(tgt[k]), 32'(op_mode));
      if (lo[k] > 0) chk("time in range", 32'h1, 32'(n >= lo[k] - 2 && n <= lo[k] + per[k] + 4));
      // A new sleep is refused until the exception states are over
      n = 0;
      do begin
        axi_rd(pmc_pkg::off_status, rd, rsp);
        n++;
      end while (rd[5:4] !== 2'b00 && n < 1000);
      chk("sequence idle", 32'h0, 32'(rd[5:4]));
      chk("status mode", 32'(tgt[k]), 32'(rd[2:0]));
      chk("cpu_run after", 32'h1, 32'(cpu_run));
      chk("mode after", 32'(tgt[k]), 32'(op_mode));
    end
    $display("test direct transfer done");
    // Exception disabled: the sleep stays a sleep
    axi_wr(pmc_pkg::off_control, 32'h0008, rsp);
    axi_wr(pmc_pkg::off_sleep, 32'h1, rsp);
    seen = 1'b0;
    repeat (200) begin
      @(posedge clk_sys);
      if (dt_exception === 1'b1) seen = 1'b1;
    end
    chk("no exception", 32'h0, 32'(seen));
    chk("mode sleep", 32'(pmc_pkg::mode_sleep), 32'(op_mode));
    chk("cpu_run", 32'h0, 32'(cpu_run));
    $display("test disabled exception done");
    reset_and_check();
    report_and_stop();
  end
endmodule
